// [bench/dphy_timing_regs_assertions.sv]
`timescale 1ns/10ps
`include "dphy_timing_defines.vh"
module dphy_timing_regs_assertions (
    // Clock, reset and register port
    input wire i_clk,
    input wire i_rst_b,
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    // Observed outputs
    input wire [7:0] o_rdata,
    input wire [6:0] o_hs_zero,
    input wire [6:0] o_hs_trail,
    input wire [6:0] o_hs_exit,
    input wire [6:0] o_clock_prepare,
    input wire [1:0] o_rate_sel
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    sequence s_ovr_zero;
        i_wr && i_addr == `HS_ZERO_OFS && i_wdata[7];
    endsequence
    // Quiet cycle after the write keeps the rate from moving under us
    sequence s_auto_trail;
        i_wr && i_addr == `HS_TRAIL_OFS && !i_wdata[7] &&
            o_rate_sel == `RATE_800 ##1 !i_wr;
    endsequence
    chk_ovr_value_used: assert property (s_ovr_zero |-> ##2
        o_hs_zero == $past(i_wdata[6:0], 2)) else $error("override lost");
    chk_auto_write_ignored: assert property (s_auto_trail |=>
        o_hs_trail == `HS_TRAIL_800) else $error("auto field written");
    chk_read_exit_value: assert property (i_rd &&
        i_addr == `HS_EXIT_OFS |=> o_rdata[6:0] == o_hs_exit)
        else $error("exit readback differs");
    chk_read_prep_value: assert property (i_rd &&
        i_addr == `CK_PREP_OFS |=> o_rdata[6:0] == o_clock_prepare)
        else $error("prepare readback differs");
    chk_rate_readback: assert property (i_rd &&
        i_addr == `RATE_SEL_OFS |=> o_rdata == {6'h00, o_rate_sel})
        else $error("rate readback differs");
    chk_reset_default: assert property ($rose(i_rst_b) |->
        o_hs_zero == `HS_ZERO_800) else $error("bad reset default");
    chk_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00)
        else $error("read data outside read cycle");
endmodule // dphy_timing_regs_assertions
bind dphy_timing_regs dphy_timing_regs_assertions i_chk (.i_clk, .i_rst_b,
    .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_hs_zero, .o_hs_trail,
    .o_hs_exit, .o_clock_prepare, .o_rate_sel);

// [bench/test_dphy_timing_regs.sv]
`timescale 1ns/10ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin bad_count++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module test_dphy_timing_regs;
    reg i_clk = 1'h0, i_rst_b = 1'h0, i_wr = 1'h0, i_rd = 1'h0;
    reg [7:0] i_addr = 8'h00, i_wdata = 8'h00;
    wire [7:0] o_rdata;
    wire [6:0] o_hs_zero, o_hs_trail, o_hs_exit, o_lpx;
    wire [6:0] o_clock_prepare, o_clock_zero;
    wire [1:0] o_rate_sel;
    wire [41:0] eff = {o_hs_zero, o_hs_trail, o_hs_exit, o_lpx,
        o_clock_prepare, o_clock_zero};
    int bad_count = 0, n_tests = 0;
    reg [7:0] ofs [6] = '{8'h45, 8'h46, 8'h47, 8'h48, 8'h60, 8'h61};
    reg [6:0] dflt [6] = '{7'h0C, 7'h08, 7'h0B, 7'h06, 7'h05, 7'h1B};
    always #50 i_clk = ~i_clk;
    dphy_timing_regs i_dphy_timing_regs (.i_clk, .i_rst_b, .i_addr,
        .i_wdata, .i_wr, .i_rd, .o_rdata, .o_hs_zero, .o_hs_trail,
        .o_hs_exit, .o_lpx, .o_clock_prepare, .o_clock_zero, .o_rate_sel);
    task wr(input [7:0] a, input [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'h1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'h0;
    endtask
    task rd(input [7:0] a, input [7:0] e);
        @(posedge i_clk);
        i_rd <= 1'h1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'h0;
        #1 `CHK(o_rdata, e)
    endtask
    task t_reset;
        for (int i = 0; i < 6; i++) begin
            rd(ofs[i], {1'h0, dflt[i]});
            `CHK(eff[41-7*i -: 7], dflt[i])
        end
        rd(8'h70, 8'h01);
        rd(8'h50, 8'h00);
    endtask
    task t_override;
        for (int i = 0; i < 6; i++) begin
            wr(ofs[i], 8'hC0 + i);
            rd(ofs[i], 8'hC0 + i);
            `CHK(eff[41-7*i -: 7], 7'h40 + i)
        end
    endtask
    task t_auto;
        for (int i = 0; i < 6; i++) begin
            wr(ofs[i], 8'h7F);
            rd(ofs[i], {1'h0, dflt[i]});
            `CHK(eff[41-7*i -: 7], dflt[i])
        end
    endtask
    // Auto values follow the rate with no recompute latency; a few idle cycles follow each change anyway
    task t_rate;
        wr(8'h70, 8'h03);
        repeat (3) @(posedge i_clk);
        rd(8'h61, 8'h36);
        `CHK(o_lpx, 7'h0C)
        wr(8'h70, 8'h00);
        repeat (3) @(posedge i_clk);
        rd(8'h61, 8'h0E);
        `CHK(o_rate_sel, 2'h0)
    endtask
    // Override holds across a rate change; auto fields follow it
    task t_hold;
        wr(8'h61, 8'h85);
        wr(8'h70, 8'h02);
        rd(8'h61, 8'h85);
        rd(8'h60, 8'h08);
        `CHK(o_clock_zero, 7'h05)
        `CHK(o_hs_zero, 7'h12)
        wr(8'h61, 8'h00);
        rd(8'h61, 8'h29);
        `CHK(o_clock_zero, 7'h29)
    endtask
    // Reset in mid-run drops overrides and returns to 800 Mbps
    task t_rerun;
        wr(8'h45, 8'h93);
        rd(8'h45, 8'h93);
        `CHK(o_hs_zero, 7'h13)
        @(posedge i_clk);
        i_rst_b <= 1'h0;
        repeat (2) @(posedge i_clk);
        `CHK(o_hs_zero, 7'h0C)
        i_rst_b <= 1'h1;
        t_reset;
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge i_clk);
        i_rst_b <= 1'h1;
        t_reset;
        t_override;
        t_auto;
        t_rate;
        t_hold;
        t_rerun;
        test_done;
    end
endmodule // test_dphy_timing_regs

// [logic/dphy_timing_defines.vh]
`ifndef DPHY_TIMING_DEFINES_VH
`define DPHY_TIMING_DEFINES_VH

// Register offsets (byte addresses on the plain register port)
`define HS_ZERO_OFS 8'h45
`define HS_TRAIL_OFS 8'h46
`define HS_EXIT_OFS 8'h47
`define LPX_OFS 8'h48
`define CK_PREP_OFS 8'h60
`define CK_ZERO_OFS 8'h61
`define RATE_SEL_OFS 8'h70

// Field layout
`define OVR_BIT 7
`define VAL_MSB 6

// Lane rate codes
`define RATE_400 2'h0
`define RATE_800 2'h1
`define RATE_1200 2'h2
`define RATE_1600 2'h3

// Automatic values at 800 Mbps, which are also the reset values
`define HS_ZERO_800 7'h0C
`define HS_TRAIL_800 7'h08
`define HS_EXIT_800 7'h0B
`define LPX_800 7'h06
`define CK_PREP_800 7'h05
`define CK_ZERO_800 7'h1B

`endif

// [logic/dphy_timing_regs.v]
// Contract
// - Bit 7 set selects written bits 6:0; clear selects the auto value.
// - Bit 7 clear makes the field read-only, reading back the auto value.
// - Bit 7 set makes the field read/write and the source of lane timing.
// - Auto values start at the 800 Mbps figures and follow the lane rate.
// - Six identical override registers: four at 0x45-0x48, two at 0x60-0x61.
`timescale 1ns/10ps
`include "dphy_timing_defines.vh"

module dphy_timing_regs (
    // Clock and reset
    input wire i_clk,
    input wire i_rst_b,
    // Register port
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [7:0] o_rdata,
    // Timing values to the lane sequencers, in byte clock cycles
    output reg [6:0] o_hs_zero,
    output reg [6:0] o_hs_trail,
    output reg [6:0] o_hs_exit,
    output reg [6:0] o_lpx,
    output reg [6:0] o_clock_prepare,
    output reg [6:0] o_clock_zero,
    // Currently selected lane rate
    output wire [1:0] o_rate_sel
);

    localparam NUM = 6;

    reg [1:0] rate_reg;
    reg [NUM-1:0] ovr_reg;
    reg [6:0] hs_zero_value_reg;
    reg [6:0] hs_trail_value_reg;
    reg [6:0] hs_exit_value_reg;
    reg [6:0] lpx_value_reg;
    reg [6:0] clock_prepare_value_reg;
    reg [6:0] clock_zero_value_reg;
    reg [NUM-1:0] ovr_next;
    reg [6:0] hs_zero_value_next;
    reg [6:0] hs_trail_value_next;
    reg [6:0] hs_exit_value_next;
    reg [6:0] lpx_value_next;
    reg [6:0] clock_prepare_value_next;
    reg [6:0] clock_zero_value_next;
    reg [7:0] rdata_next;
    wire [6:0] hs_zero_auto;
    wire [6:0] hs_trail_auto;
    wire [6:0] hs_exit_auto;
    wire [6:0] lpx_auto;
    wire [6:0] clock_prepare_auto;
    wire [6:0] clock_zero_auto;
    wire [6:0] hs_zero_eff;
    wire [6:0] hs_trail_eff;
    wire [6:0] hs_exit_eff;
    wire [6:0] lpx_eff;
    wire [6:0] clock_prepare_eff;
    wire [6:0] clock_zero_eff;
    wire [NUM-1:0] wr_hit;
    wire rate_wr;
    integer n;

    // Scale an 800 Mbps figure to another rate; byte clock is rate/8
    // so cycle counts grow roughly with rate. Rounded up to stay legal.
    function [6:0] scale;
        input [6:0] base;
        input [1:0] rate;
        reg [8:0] t;
        begin
            t = 9'h000;
            case (rate)
                `RATE_400: t = ({2'h0, base} + 9'h001) >> 1;
                `RATE_800: t = {2'h0, base};
                `RATE_1200: t = {2'h0, base} + (({2'h0, base} + 9'h001) >> 1);
                `RATE_1600: t = {1'h0, base, 1'h0};
                default: t = {2'h0, base};
            endcase
            scale = (t > 9'h07F) ? 7'h7F : t[6:0];
        end
    endfunction

    // Register index for an address, NUM when unmapped
    function [2:0] reg_idx;
        input [7:0] a;
        begin
            case (a)
                `HS_ZERO_OFS: reg_idx = 3'h0;
                `HS_TRAIL_OFS: reg_idx = 3'h1;
                `HS_EXIT_OFS: reg_idx = 3'h2;
                `LPX_OFS: reg_idx = 3'h3;
                `CK_PREP_OFS: reg_idx = 3'h4;
                `CK_ZERO_OFS: reg_idx = 3'h5;
                default: reg_idx = 3'h6;
            endcase
        end
    endfunction

    // Next stored field. Without override the field shadows the
    // automatic value, so a write that clears the bit drops the old
    // software value instead of reviving it later.
    function [6:0] field_next;
        input hit;
        input [7:0] wdata;
        input ovr;
        input [6:0] cur;
        input [6:0] auto_v;
        begin
            if (hit && wdata[`OVR_BIT]) begin
                field_next = wdata[`VAL_MSB:0];
            end else if (hit || !ovr) begin
                field_next = auto_v;
            end else begin
                field_next = cur;
            end
        end
    endfunction

    // Value the lane sequencer uses
    function [6:0] effective;
        input ovr;
        input [6:0] stored;
        input [6:0] auto_v;
        begin
            effective = ovr ? stored : auto_v;
        end
    endfunction

    // Write decode; unmapped addresses hit nothing
    assign rate_wr = i_wr && (i_addr == `RATE_SEL_OFS);
    assign wr_hit[0] = i_wr && (reg_idx(i_addr) == 3'h0);
    assign wr_hit[1] = i_wr && (reg_idx(i_addr) == 3'h1);
    assign wr_hit[2] = i_wr && (reg_idx(i_addr) == 3'h2);
    assign wr_hit[3] = i_wr && (reg_idx(i_addr) == 3'h3);
    assign wr_hit[4] = i_wr && (reg_idx(i_addr) == 3'h4);
    assign wr_hit[5] = i_wr && (reg_idx(i_addr) == 3'h5);

    // Automatic values follow the rate combinationally, so a rate change
    // is seen on the next read with no recompute latency.
    assign hs_zero_auto = scale(`HS_ZERO_800, rate_reg);
    assign hs_trail_auto = scale(`HS_TRAIL_800, rate_reg);
    assign hs_exit_auto = scale(`HS_EXIT_800, rate_reg);
    assign lpx_auto = scale(`LPX_800, rate_reg);
    assign clock_prepare_auto = scale(`CK_PREP_800, rate_reg);
    assign clock_zero_auto = scale(`CK_ZERO_800, rate_reg);

    assign hs_zero_eff = effective(ovr_reg[0], hs_zero_value_reg,
        hs_zero_auto);
    assign hs_trail_eff = effective(ovr_reg[1], hs_trail_value_reg,
        hs_trail_auto);
    assign hs_exit_eff = effective(ovr_reg[2], hs_exit_value_reg,
        hs_exit_auto);
    assign lpx_eff = effective(ovr_reg[3], lpx_value_reg,
        lpx_auto);
    assign clock_prepare_eff = effective(ovr_reg[4],
        clock_prepare_value_reg, clock_prepare_auto);
    assign clock_zero_eff = effective(ovr_reg[5],
        clock_zero_value_reg, clock_zero_auto);

    always @* begin
        ovr_next = ovr_reg;
        for (n = 0; n < NUM; n = n + 1) begin
            if (wr_hit[n]) begin
                ovr_next[n] = i_wdata[`OVR_BIT];
            end
        end
    end

    always @* begin
        hs_zero_value_next = field_next(wr_hit[0], i_wdata,
            ovr_reg[0], hs_zero_value_reg, hs_zero_auto);
        hs_trail_value_next = field_next(wr_hit[1], i_wdata,
            ovr_reg[1], hs_trail_value_reg, hs_trail_auto);
        hs_exit_value_next = field_next(wr_hit[2], i_wdata,
            ovr_reg[2], hs_exit_value_reg, hs_exit_auto);
        lpx_value_next = field_next(wr_hit[3], i_wdata,
            ovr_reg[3], lpx_value_reg, lpx_auto);
        clock_prepare_value_next = field_next(wr_hit[4], i_wdata,
            ovr_reg[4], clock_prepare_value_reg, clock_prepare_auto);
        clock_zero_value_next = field_next(wr_hit[5], i_wdata,
            ovr_reg[5], clock_zero_value_reg, clock_zero_auto);
    end

    // Reads return the override bit beside the value in use
    always @* begin
        rdata_next = 8'h00;
        case (i_addr)
            `HS_ZERO_OFS: begin
                rdata_next = {ovr_reg[0], hs_zero_eff};
            end
            `HS_TRAIL_OFS: begin
                rdata_next = {ovr_reg[1], hs_trail_eff};
            end
            `HS_EXIT_OFS: begin
                rdata_next = {ovr_reg[2], hs_exit_eff};
            end
            `LPX_OFS: begin
                rdata_next = {ovr_reg[3], lpx_eff};
            end
            `CK_PREP_OFS: begin
                rdata_next = {ovr_reg[4], clock_prepare_eff};
            end
            `CK_ZERO_OFS: begin
                rdata_next = {ovr_reg[5], clock_zero_eff};
            end
            `RATE_SEL_OFS: begin
                rdata_next = {6'h00, rate_reg};
            end
            default: begin
                rdata_next = 8'h00;
            end
        endcase
    end

    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rate_reg <= `RATE_800;
            ovr_reg <= {NUM{1'h0}};
            hs_zero_value_reg <= `HS_ZERO_800;
            hs_trail_value_reg <= `HS_TRAIL_800;
            hs_exit_value_reg <= `HS_EXIT_800;
            lpx_value_reg <= `LPX_800;
            clock_prepare_value_reg <= `CK_PREP_800;
            clock_zero_value_reg <= `CK_ZERO_800;
            o_rdata <= 8'h00;
        end else begin
            if (rate_wr) begin
                rate_reg <= i_wdata[1:0];
            end
            ovr_reg <= ovr_next;
            hs_zero_value_reg <= hs_zero_value_next;
            hs_trail_value_reg <= hs_trail_value_next;
            hs_exit_value_reg <= hs_exit_value_next;
            lpx_value_reg <= lpx_value_next;
            clock_prepare_value_reg <= clock_prepare_value_next;
            clock_zero_value_reg <= clock_zero_value_next;
            o_rdata <= i_rd ? rdata_next : 8'h00;
        end
    end

    // Timing outputs registered; the consumer counts byte clock cycles
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_hs_zero <= `HS_ZERO_800;
            o_hs_trail <= `HS_TRAIL_800;
            o_hs_exit <= `HS_EXIT_800;
            o_lpx <= `LPX_800;
            o_clock_prepare <= `CK_PREP_800;
            o_clock_zero <= `CK_ZERO_800;
        end else begin
            o_hs_zero <= hs_zero_eff;
            o_hs_trail <= hs_trail_eff;
            o_hs_exit <= hs_exit_eff;
            o_lpx <= lpx_eff;
            o_clock_prepare <= clock_prepare_eff;
            o_clock_zero <= clock_zero_eff;
        end
    end

    assign o_rate_sel = rate_reg;

endmodule // dphy_timing_regs
